// [host_port_pkg.sv]
// shared constants for the host cpu port configuration group
package host_port_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // device register addresses
  localparam logic [7:0] ADDR_DMA_WR_LO    = 8'h6E;
  localparam logic [7:0] ADDR_DMA_WR_HI    = 8'h6F;
  localparam logic [7:0] ADDR_LOCK         = 8'h71;
  localparam logic [7:0] ADDR_CLK_SEL      = 8'h73;
  localparam logic [7:0] ADDR_BUS_CFG      = 8'h75;
  localparam logic [7:0] ADDR_SWAP_APPLY   = 8'h77;

  // reset values and key
  localparam logic [7:0] LOCK_KEY          = 8'h56;
  localparam logic [7:0] LOCK_RESET        = 8'h56;
  localparam logic [7:0] CLK_SEL_RESET     = 8'h00;
  localparam logic [7:0] BUS_CFG_RESET     = 8'h00;
  localparam logic [7:0] RELOCK_VALUE      = 8'h00;
  localparam logic [7:0] CLK_SEL_MASK      = 8'h83;
  localparam logic [7:0] BYTE_ZERO         = 8'h00;

  // clock select fields
  localparam int         CLK_ORIGIN_BIT    = 7;
  localparam logic [1:0] FREQ_12M          = 2'h0;
  localparam logic [1:0] FREQ_24M          = 2'h1;
  localparam logic [1:0] FREQ_48M          = 2'h3;

  // bus configuration fields
  localparam int         CFG_IRQ_POL       = 7;
  localparam int         CFG_IRQ_DRIVE     = 6;
  localparam int         CFG_DREQ_POL      = 5;
  localparam int         CFG_DACK_POL      = 4;
  localparam int         CFG_CS_QUAL       = 3;
  localparam int         CFG_SWAP          = 2;
  localparam int         CFG_BE_MODE       = 1;
  localparam int         CFG_BUS8          = 0;

  ////////////////////////////////////////////////////////////////////////////
  // host bridge software map (word indices)
  localparam logic [9:0] HOST_CTRL_IDX     = 10'h100;
  localparam logic [9:0] HOST_STAT_IDX     = 10'h101;
  localparam int         HC_DIR_WRITE      = 0;
  localparam int         HC_AUTO_RELOCK    = 1;
  localparam int         HS_REFUSED        = 0;
  localparam int         HS_CLK_DONE       = 1;
  localparam int         HS_SWAP           = 2;
  localparam logic [1:0] HOST_CTRL_RESET   = 2'h2;

  // bus strobe hold in clk_i cycles
  localparam int         STROBE_HOLD       = 2;

endpackage : host_port_pkg

// [host_port_if.sv]
// parallel host cpu bus between the bridge and the configuration block
`timescale 1ns/100ps
interface host_port_if;
  logic        chip_select_pin_n;
  logic        rd_n;
  logic        wr_n;
  logic        wr_strobe_hi_n;
  logic        wr_strobe_lo_n;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        dma_ack_pin;
  logic        dma_request_pin;
  logic        irq_pin_out;
  logic        irq_pin_oe;
  logic        irq_pin;

  // undriven pin is pulled to its inactive level, which out holds while released
  assign irq_pin = irq_pin_oe ? irq_pin_out : irq_pin_out;

  modport device (
    input  chip_select_pin_n, rd_n, wr_n, wr_strobe_hi_n, wr_strobe_lo_n, addr, wdata, dma_ack_pin,
    output rdata, dma_request_pin, irq_pin_out, irq_pin_oe
  );

  modport host (
    output chip_select_pin_n, rd_n, wr_n, wr_strobe_hi_n, wr_strobe_lo_n, addr, wdata, dma_ack_pin,
    input  rdata, dma_request_pin, irq_pin
  );
endinterface : host_port_if

// [byte_lane_decode.sv]
// address decode and read selection for one byte lane
`timescale 1ns/100ps
module byte_lane_decode
  import host_port_pkg::*;
(
  // lane address and register values
  input  wire logic [7:0] lane_addr_i,
  input  wire logic [7:0] lock_i,
  input  wire logic [7:0] clk_sel_i,
  input  wire logic [7:0] bus_cfg_i,
  // decode results
  output wire logic       hit_lock_o,
  output wire logic       hit_clk_o,
  output wire logic       hit_cfg_o,
  output wire logic       hit_dma_o,
  output wire logic       hit_apply_o,
  output wire logic [7:0] rd_byte_o
);
  assign hit_lock_o  = (lane_addr_i == ADDR_LOCK);
  assign hit_clk_o   = (lane_addr_i == ADDR_CLK_SEL);
  assign hit_cfg_o   = (lane_addr_i == ADDR_BUS_CFG);
  assign hit_dma_o   = (lane_addr_i == ADDR_DMA_WR_LO) || (lane_addr_i == ADDR_DMA_WR_HI);
  assign hit_apply_o = (lane_addr_i == ADDR_SWAP_APPLY);

  // write-only and unmapped addresses read as zero
  assign rd_byte_o = hit_lock_o ? lock_i :
                     hit_clk_o  ? (clk_sel_i & CLK_SEL_MASK) :
                     hit_cfg_o  ? bus_cfg_i : BYTE_ZERO;
endmodule : byte_lane_decode

// [host_port_device.sv]
// configuration register group and dma write port of the device end
`timescale 1ns/100ps
module host_port_device
  import host_port_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // parallel cpu bus
  host_port_if.device      bus,
  // system controls
  input  wire logic        cpu_cut_i,
  input  wire logic        global_soft_reset_i,
  input  wire logic        dma_register_mode_i,
  input  wire logic        irq_request_i,
  input  wire logic        dma_request_i,
  // fifo write side, bit 1 = high lane byte
  output logic [1:0]       fifo_push_o,
  output logic [15:0]      fifo_data_o,
  // decoded configuration
  output logic             dma_access_o,
  output logic             clock_origin_o,
  output logic [1:0]       input_freq_code_o,
  output logic             external_clock_enable_o,
  output logic             bus_width_8_o,
  output logic             byte_enable_mode_o,
  output logic             swap_active_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0]  lock_reg,    lock_next;
  logic [7:0]  clk_sel_reg, clk_sel_next;
  logic [7:0]  bus_cfg_reg, bus_cfg_next;
  logic        swap_reg,    swap_next;
  logic [1:0]  wr_prev_reg;
  logic        rd_prev_reg;
  logic [15:0] rdata_reg,   rdata_next;
  logic        dreq_pin_reg;
  logic        irq_out_reg;
  logic        irq_oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // bus qualification
  wire        bus_ok   = ~cpu_cut_i;
  wire        cs_act   = bus_ok & ~bus.chip_select_pin_n;
  wire        be_mode  = bus_cfg_reg[CFG_BE_MODE];
  wire        bus8     = bus_cfg_reg[CFG_BUS8] & ~be_mode;
  wire        wr_gate  = ~be_mode | ~bus.wr_n;
  wire        hi_wr    = cs_act & ~bus8 & ~bus.wr_strobe_hi_n & wr_gate;
  wire        lo_wr    = cs_act & ~bus.wr_strobe_lo_n & wr_gate;
  wire        rd_act   = cs_act & ~bus.rd_n;
  // act once per strobe, so a long strobe pushes a single byte
  wire        hi_ev    = hi_wr & ~wr_prev_reg[1];
  wire        lo_ev    = lo_wr & ~wr_prev_reg[0];
  wire        rd_ev    = rd_act & ~rd_prev_reg;

  // lane addresses; even address is the upper byte unless swapped; 8-bit mode puts every address on the lower byte
  wire [7:0]  even_adr = {bus.addr[7:1], 1'b0};
  wire [7:0]  odd_adr  = {bus.addr[7:1], 1'b1};
  wire [7:0]  hi_adr   = swap_reg ? odd_adr : even_adr;
  wire [7:0]  lo_adr   = bus8 ? bus.addr : (swap_reg ? even_adr : odd_adr);
  wire [7:0]  hi_byte  = bus.wdata[15:8];
  wire [7:0]  lo_byte  = bus.wdata[7:0];

  wire        hi_lock, hi_clk, hi_cfg, hi_dma, hi_apply;
  wire        lo_lock, lo_clk, lo_cfg, lo_dma, lo_apply;
  wire [7:0]  hi_rd, lo_rd;

  byte_lane_decode u_lane_hi (
    .lane_addr_i (hi_adr),
    .lock_i      (lock_reg),
    .clk_sel_i   (clk_sel_reg),
    .bus_cfg_i   (bus_cfg_reg),
    .hit_lock_o  (hi_lock),
    .hit_clk_o   (hi_clk),
    .hit_cfg_o   (hi_cfg),
    .hit_dma_o   (hi_dma),
    .hit_apply_o (hi_apply),
    .rd_byte_o   (hi_rd)
  );

  byte_lane_decode u_lane_lo (
    .lane_addr_i (lo_adr),
    .lock_i      (lock_reg),
    .clk_sel_i   (clk_sel_reg),
    .bus_cfg_i   (bus_cfg_reg),
    .hit_lock_o  (lo_lock),
    .hit_clk_o   (lo_clk),
    .hit_cfg_o   (lo_cfg),
    .hit_dma_o   (lo_dma),
    .hit_apply_o (lo_apply),
    .rd_byte_o   (lo_rd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register writes; no sleep gating, so all stay reachable
  wire        unlocked = (lock_reg == LOCK_KEY);
  wire        wr_lock  = (hi_ev & hi_lock) | (lo_ev & lo_lock);
  wire        wr_clk   = unlocked & ((hi_ev & hi_clk) | (lo_ev & lo_clk));
  wire        wr_cfg   = unlocked & ((hi_ev & hi_cfg) | (lo_ev & lo_cfg));
  wire [7:0]  lock_in  = (hi_ev & hi_lock) ? hi_byte : lo_byte;
  wire [7:0]  clk_in   = (hi_ev & hi_clk) ? hi_byte : lo_byte;
  wire [7:0]  cfg_in   = (hi_ev & hi_cfg) ? hi_byte : lo_byte;
  wire        apply    = rd_ev & (lo_apply | (~bus8 & hi_apply));

  assign lock_next    = global_soft_reset_i ? LOCK_RESET :
                        wr_lock ? lock_in : lock_reg;
  assign clk_sel_next = global_soft_reset_i ? CLK_SEL_RESET :
                        wr_clk ? (clk_in & CLK_SEL_MASK) : clk_sel_reg;
  assign bus_cfg_next = global_soft_reset_i ? BUS_CFG_RESET :
                        wr_cfg ? cfg_in : bus_cfg_reg;
  // soft reset clears the setting but the lane swap waits for the dummy read
  assign swap_next    = apply ? bus_cfg_reg[CFG_SWAP] : swap_reg;
  assign rdata_next   = rd_ev ? {(bus8 ? BYTE_ZERO : hi_rd), lo_rd} : rdata_reg;

  // dma port: either address is a byte port in 8-bit mode
  wire        push_hi  = dma_register_mode_i & hi_ev & hi_dma;
  wire        push_lo  = dma_register_mode_i & lo_ev & lo_dma;

  ////////////////////////////////////////////////////////////////////////////
  // pins
  wire        irq_pol  = bus_cfg_reg[CFG_IRQ_POL];
  wire        irq_lvl  = irq_request_i ? irq_pol : ~irq_pol;
  wire        irq_drv  = ~bus_cfg_reg[CFG_IRQ_DRIVE] | irq_request_i;
  wire        dreq_lvl = ~(dma_request_i ^ bus_cfg_reg[CFG_DREQ_POL]);
  wire        dack_act = bus_ok & (bus.dma_ack_pin == bus_cfg_reg[CFG_DACK_POL]);
  wire        dma_ok   = dack_act & (~bus_cfg_reg[CFG_CS_QUAL] | cs_act);

  assign bus.rdata           = rdata_reg;
  assign bus.dma_request_pin = dreq_pin_reg;
  assign bus.irq_pin_out     = irq_out_reg;
  assign bus.irq_pin_oe      = irq_oe_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_reg     <= LOCK_RESET;
      clk_sel_reg  <= CLK_SEL_RESET;
      bus_cfg_reg  <= BUS_CFG_RESET;
      swap_reg     <= 1'b0;
      wr_prev_reg  <= 2'b00;
      rd_prev_reg  <= 1'b0;
      rdata_reg    <= 16'h0000;
    end else begin
      lock_reg     <= lock_next;
      clk_sel_reg  <= clk_sel_next;
      bus_cfg_reg  <= bus_cfg_next;
      swap_reg     <= swap_next;
      wr_prev_reg  <= {hi_wr, lo_wr};
      rd_prev_reg  <= rd_act;
      rdata_reg    <= rdata_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fifo_push_o             <= 2'b00;
      fifo_data_o             <= 16'h0000;
      dma_access_o            <= 1'b0;
      dreq_pin_reg            <= 1'b1;
      irq_out_reg             <= 1'b1;
      irq_oe_reg              <= 1'b1;
    end else begin
      fifo_push_o             <= {push_hi, push_lo};
      fifo_data_o             <= bus.wdata;
      dma_access_o            <= dma_ok;
      dreq_pin_reg            <= dreq_lvl;
      irq_out_reg             <= irq_lvl;
      irq_oe_reg              <= irq_drv;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clock_origin_o          <= 1'b0;
      input_freq_code_o       <= FREQ_12M;
      external_clock_enable_o <= 1'b0;
      bus_width_8_o           <= 1'b0;
      byte_enable_mode_o      <= 1'b0;
      swap_active_o           <= 1'b0;
    end else begin
      clock_origin_o          <= clk_sel_reg[CLK_ORIGIN_BIT];
      input_freq_code_o       <= clk_sel_reg[1:0];
      external_clock_enable_o <= clk_sel_reg[CLK_ORIGIN_BIT] & bus_ok;
      bus_width_8_o           <= bus8;
      byte_enable_mode_o      <= be_mode;
      swap_active_o           <= swap_reg;
    end
  end

endmodule : host_port_device

// [host_port_host.sv]
// wishbone bridge that drives the parallel cpu bus as the host
`timescale 1ns/100ps
module host_port_host
  import host_port_pkg::*;
#(
  parameter int HOLD = STROBE_HOLD
)(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // classic wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // user side
  input  wire logic        dma_ack_i,
  output logic             irq_active_o,
  output logic             dma_req_active_o,
  // parallel cpu bus
  host_port_if.host        bus
);

  // read data is taken in the gap cycle, so a single-cycle strobe is too short
  if (HOLD < 2 || HOLD > 3) begin : g_hold_check
    $error("HOLD must be 2 or 3");
  end

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_DRIVE = 3'b010,
    ST_GAP   = 3'b100
  } host_state_e;

  host_state_e state_reg;
  logic [1:0]  cnt_reg;
  logic [7:0]  op_adr_reg;
  logic [7:0]  op_dat_reg;
  logic        op_we_reg;
  logic        op_sw_reg;
  logic        pend_apply_reg;
  logic        pend_relock_reg;
  logic [1:0]  ctrl_reg;
  logic        refused_reg;
  logic        clk_done_reg;
  logic        lock_open_reg;
  logic [7:0]  cfg_shadow_reg;
  logic        swap_reg;

  ////////////////////////////////////////////////////////////////////////////
  // request decode
  wire [9:0]  idx      = wb_adr_i[11:2];
  wire [7:0]  dadr     = idx[7:0];
  wire [7:0]  wbyte    = wb_dat_i[7:0];
  wire        req      = wb_cyc_i & wb_stb_i & ~wb_ack_o & (state_reg == ST_IDLE);
  wire        is_dev   = (idx[9:8] == 2'b00);
  wire        do_wr    = wb_we_i & wb_sel_i[0];
  wire        bad_clk  = (dadr == ADDR_CLK_SEL) & ~wbyte[CLK_ORIGIN_BIT] & (wbyte[1:0] == FREQ_48M);
  wire        bad_swap = (dadr == ADDR_BUS_CFG) & wbyte[CFG_SWAP] & wbyte[CFG_BUS8] & ~wbyte[CFG_BE_MODE];
  wire        bad_dma  = ((dadr == ADDR_DMA_WR_LO) | (dadr == ADDR_DMA_WR_HI)) & ~ctrl_reg[HC_DIR_WRITE];
  wire        early    = ~clk_done_reg & (dadr != ADDR_CLK_SEL) & (dadr != ADDR_LOCK);
  wire        refuse   = is_dev & (early | (do_wr & (bad_clk | bad_swap | bad_dma)));
  wire        wr_prot  = (dadr == ADDR_CLK_SEL) | (dadr == ADDR_BUS_CFG);
  wire        start    = req & is_dev & ~refuse & (wb_we_i ? wb_sel_i[0] : 1'b1);
  wire        last     = (state_reg == ST_DRIVE) & (cnt_reg == 2'(HOLD - 1));

  // lane choice follows the device's active swap and width
  wire        bus8     = cfg_shadow_reg[CFG_BUS8] & ~cfg_shadow_reg[CFG_BE_MODE];
  wire        use_hi   = ~bus8 & (op_adr_reg[0] == swap_reg);
  wire [7:0]  rd_byte  = use_hi ? bus.rdata[15:8] : bus.rdata[7:0];
  wire        lane_en  = op_we_reg | cfg_shadow_reg[CFG_BE_MODE];
  wire        drive    = (state_reg == ST_DRIVE);
  wire [31:0] host_rd  = (idx == HOST_CTRL_IDX) ? {30'h0, ctrl_reg} :
                         (idx == HOST_STAT_IDX) ? {29'h0, swap_reg, clk_done_reg, refused_reg} :
                         is_dev ? wb_dat_o : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg       <= ST_IDLE;
      cnt_reg         <= 2'b00;
      op_adr_reg      <= BYTE_ZERO;
      op_dat_reg      <= BYTE_ZERO;
      op_we_reg       <= 1'b0;
      op_sw_reg       <= 1'b0;
      pend_apply_reg  <= 1'b0;
      pend_relock_reg <= 1'b0;
      wb_ack_o        <= 1'b0;
      wb_dat_o        <= 32'h0000_0000;
    end else begin
      wb_ack_o <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          if (start) begin
            state_reg       <= ST_DRIVE;
            cnt_reg         <= 2'b00;
            op_adr_reg      <= dadr;
            op_dat_reg      <= wbyte;
            op_we_reg       <= wb_we_i;
            op_sw_reg       <= 1'b1;
            pend_apply_reg  <= do_wr & (dadr == ADDR_BUS_CFG) & lock_open_reg;
            pend_relock_reg <= do_wr & wr_prot & lock_open_reg & ctrl_reg[HC_AUTO_RELOCK];
          end else if (req) begin
            wb_ack_o <= 1'b1;
            wb_dat_o <= host_rd;
          end
        end
        ST_DRIVE: begin
          cnt_reg <= cnt_reg + 2'b01;
          if (last) begin
            state_reg <= ST_GAP;
          end
        end
        ST_GAP: begin
          cnt_reg   <= 2'b00;
          op_sw_reg <= 1'b0;
          // device read data stands from the edge that took the strobe
          if (op_sw_reg & ~op_we_reg) begin
            wb_dat_o <= {24'h000000, rd_byte};
          end
          if (pend_apply_reg) begin
            state_reg      <= ST_DRIVE;
            pend_apply_reg <= 1'b0;
            op_adr_reg     <= ADDR_SWAP_APPLY;
            op_we_reg      <= 1'b0;
          end else if (pend_relock_reg) begin
            state_reg       <= ST_DRIVE;
            pend_relock_reg <= 1'b0;
            op_adr_reg      <= ADDR_LOCK;
            op_dat_reg      <= RELOCK_VALUE;
            op_we_reg       <= 1'b1;
          end else begin
            state_reg <= ST_IDLE;
            wb_ack_o  <= 1'b1;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers and device shadows
  wire        op_done  = last & op_we_reg;
  wire        set_ref  = req & refuse;
  wire        clr_ref  = req & (idx == HOST_STAT_IDX) & do_wr & wbyte[HS_REFUSED];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg       <= HOST_CTRL_RESET;
      refused_reg    <= 1'b0;
      clk_done_reg   <= 1'b0;
      lock_open_reg  <= 1'b1;
      cfg_shadow_reg <= BUS_CFG_RESET;
      swap_reg       <= 1'b0;
    end else begin
      if (req & (idx == HOST_CTRL_IDX) & do_wr) begin
        ctrl_reg <= wb_dat_i[1:0];
      end
      // a refusal in the clearing cycle stays set
      refused_reg <= set_ref | (refused_reg & ~clr_ref);
      if (op_done & (op_adr_reg == ADDR_LOCK)) begin
        lock_open_reg <= (op_dat_reg == LOCK_KEY);
      end
      if (op_done & lock_open_reg & (op_adr_reg == ADDR_CLK_SEL)) begin
        clk_done_reg <= 1'b1;
      end
      if (op_done & lock_open_reg & (op_adr_reg == ADDR_BUS_CFG)) begin
        cfg_shadow_reg <= op_dat_reg;
      end
      if (last & ~op_we_reg & (op_adr_reg == ADDR_SWAP_APPLY)) begin
        swap_reg <= cfg_shadow_reg[CFG_SWAP];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus.chip_select_pin_n <= 1'b1;
      bus.rd_n              <= 1'b1;
      bus.wr_n              <= 1'b1;
      bus.wr_strobe_hi_n    <= 1'b1;
      bus.wr_strobe_lo_n    <= 1'b1;
      bus.addr              <= BYTE_ZERO;
      bus.wdata             <= 16'h0000;
      bus.dma_ack_pin       <= 1'b1;
      irq_active_o          <= 1'b0;
      dma_req_active_o      <= 1'b0;
    end else begin
      bus.chip_select_pin_n <= ~drive;
      bus.rd_n              <= ~(drive & ~op_we_reg);
      bus.wr_n              <= ~(drive & op_we_reg);
      bus.wr_strobe_hi_n    <= ~(drive & lane_en & use_hi);
      bus.wr_strobe_lo_n    <= ~(drive & lane_en & ~use_hi);
      bus.addr              <= op_adr_reg;
      bus.wdata             <= {op_dat_reg, op_dat_reg};
      bus.dma_ack_pin       <= ~(dma_ack_i ^ cfg_shadow_reg[CFG_DACK_POL]);
      irq_active_o          <= (bus.irq_pin == cfg_shadow_reg[CFG_IRQ_POL]);
      dma_req_active_o      <= (bus.dma_request_pin == cfg_shadow_reg[CFG_DREQ_POL]);
    end
  end

endmodule : host_port_host

// [host_cpu_port_config_regs_checker.sv]
// assertions on the parallel host cpu bus
`timescale 1ns/100ps
module host_cpu_port_config_regs_checker
  import host_port_pkg::*;
(
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // host cpu bus
  input wire logic        chip_select_pin_n,
  input wire logic        rd_n,
  input wire logic        wr_n,
  input wire logic [7:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic        dma_request_pin,
  input wire logic        irq_pin_out,
  input wire logic        irq_pin_oe
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////
  a_reset_pins_idle: assert property (disable iff (1'b0) rst_i |=>
    chip_select_pin_n && rd_n && wr_n && dma_request_pin && irq_pin_out && irq_pin_oe) else $error("pins busy in reset");
  a_write_hold: assert property ($fell(wr_n) |-> !wr_n ##1 !wr_n ##1 wr_n)
    else $error("write strobe length wrong");
  a_read_hold: assert property ($fell(rd_n) |-> !rd_n ##1 !rd_n ##1 rd_n)
    else $error("read strobe length wrong");
  a_write_stable: assert property (!wr_n && !$past(wr_n) |-> $stable(addr) && $stable(wdata))
    else $error("write moved under strobe");
  a_strobe_selected: assert property (!wr_n || !rd_n |-> !chip_select_pin_n)
    else $error("strobe without chip select");
  a_swap_dummy_read: assert property ($rose(wr_n) && $past(addr) == ADDR_BUS_CFG |->
    ##[1:2] !rd_n && addr == ADDR_SWAP_APPLY) else $error("no dummy read after config write");
  a_auto_relock: assert property ($rose(rd_n) && $past(addr) == ADDR_SWAP_APPLY |->
    ##[1:2] !wr_n && addr == ADDR_LOCK) else $error("no relock after config");
  a_rdata_quiet: assert property (rd_n && $past(rd_n) && $past(rd_n, 2) |-> $stable(rdata))
    else $error("read data moved without read");
endmodule : host_cpu_port_config_regs_checker

// [host_cpu_port_config_regs_test.sv]
// self-checking bench for the host port configuration group
`timescale 1ns/100ps
module host_cpu_port_config_regs_test
  import host_port_pkg::*;
();
  logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, dma_ack_u, irq_act, dreq_act, dacc, corg, xclk_en;
  logic        cut, srst, dmode, irq_rq, dma_rq, b8, bem, swp;
  logic [1:0]  freq, push, push_seen;
  logic [7:0]  push_byte, c, v, d;
  logic [11:0] wb_adr;
  logic [15:0] fdat;
  logic [31:0] wb_dw, wb_dr, rq;
  int          failures = 0;
  int          checks = 0;
  host_port_if bus_if ();
  host_port_host host_port_host_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'h1), .wb_dat_i(wb_dw), .wb_dat_o(wb_dr), .wb_ack_o(wb_ack),
    .dma_ack_i(dma_ack_u), .irq_active_o(irq_act), .dma_req_active_o(dreq_act), .bus(bus_if.host));
  host_port_device host_port_device_i (.clk_i(clk_i), .rst_i(rst_i), .bus(bus_if.device), .cpu_cut_i(cut),
    .global_soft_reset_i(srst), .dma_register_mode_i(dmode), .irq_request_i(irq_rq), .dma_request_i(dma_rq),
    .fifo_push_o(push), .fifo_data_o(fdat), .dma_access_o(dacc), .clock_origin_o(corg), .input_freq_code_o(freq),
    .external_clock_enable_o(xclk_en), .bus_width_8_o(b8), .byte_enable_mode_o(bem), .swap_active_o(swp));
  host_cpu_port_config_regs_checker host_cpu_port_config_regs_checker_i (.clk_i(clk_i), .rst_i(rst_i),
    .chip_select_pin_n(bus_if.chip_select_pin_n), .rd_n(bus_if.rd_n), .wr_n(bus_if.wr_n), .addr(bus_if.addr),
    .wdata(bus_if.wdata), .rdata(bus_if.rdata), .dma_request_pin(bus_if.dma_request_pin),
    .irq_pin_out(bus_if.irq_pin_out), .irq_pin_oe(bus_if.irq_pin_oe));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
    if (push !== 2'h0) begin
      push_seen <= push;
      push_byte <= push[1] ? fdat[15:8] : fdat[7:0];
    end
  task automatic summarize;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // called just after an edge; request held until ack is sampled
  task automatic wb(input logic w, input logic [9:0] i, input logic [7:0] dat);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_dw} <= {2'h3, w, i, 2'h0, 24'h0, dat};
    do
      @(posedge clk_i);
    while (wb_ack !== 1'b1);
    rq = wb_dr;
    {wb_cyc, wb_stb} <= 2'h0;
    @(posedge clk_i);
  endtask : wb
  task automatic rdchk(input logic [9:0] i, input logic [7:0] e);
    wb(1'b0, i, 8'h00);
    chk(rq, {24'h0, e});
  endtask : rdchk
  task automatic set(input logic [7:0] a, input logic [7:0] dat);
    wb(1'b1, 10'(ADDR_LOCK), LOCK_KEY);
    wb(1'b1, 10'(a), dat);
    repeat (3) @(posedge clk_i);
  endtask : set
  function automatic logic [1:0] lane(input logic [7:0] a, input logic [7:0] cfg);
    if (cfg[1:0] == 2'h1) return 2'h1;
    return (a[0] ^ cfg[2]) ? 2'h1 : 2'h2;
  endfunction : lane
  initial begin
    {rst_i, wb_cyc, wb_stb, wb_we, wb_adr, wb_dw} = {1'b1, 47'h0};
    {dma_ack_u, cut, srst, dmode, irq_rq, dma_rq, push_seen} = 8'h0;
    void'($urandom(32'hA7FC6325));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(10'(ADDR_LOCK), LOCK_RESET);
    rdchk(10'(ADDR_CLK_SEL), CLK_SEL_RESET);
    wb(1'b1, HOST_CTRL_IDX, 8'h03);
    set(ADDR_CLK_SEL, 8'h03);
    rdchk(HOST_STAT_IDX, 8'h01);
    wb(1'b1, HOST_STAT_IDX, 8'h01);
    for (int i = 0; i < 6; i++) begin
      if (i == 4) continue;
      v = {i[0], 5'($urandom), (i > 3) ? FREQ_48M : (i > 1) ? FREQ_24M : FREQ_12M};
      set(ADDR_CLK_SEL, v);
      rdchk(10'(ADDR_CLK_SEL), v & CLK_SEL_MASK);
      chk(32'({corg, freq, xclk_en}), 32'({v[7], v[1:0], v[7]}));
    end
    rdchk(10'(ADDR_LOCK), RELOCK_VALUE);
    wb(1'b1, 10'(ADDR_CLK_SEL), 8'h01);
    rdchk(10'(ADDR_CLK_SEL), 8'h83);
    $display("clock select and lock test done");
    dmode <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      c = (k == 0) ? 8'h01 : (k == 1) ? 8'h04 : 8'($urandom);
      if (c[1:0] == 2'h1) c[2] = 1'b0;
      set(ADDR_BUS_CFG, c);
      rdchk(10'(ADDR_BUS_CFG), c);
      {irq_rq, dma_rq, dma_ack_u} <= 3'h7;
      repeat (4) @(posedge clk_i);
      chk(32'({b8, bem, swp, irq_act, dreq_act}), 32'({c[0] & ~c[1], c[1], c[2], 2'h3}));
      chk(32'({bus_if.irq_pin, bus_if.irq_pin_oe, bus_if.dma_request_pin, bus_if.dma_ack_pin, dacc}),
          32'({c[7], 1'b1, c[5:4], ~c[3]}));
      {irq_rq, dma_rq, dma_ack_u} <= 3'h0;
      repeat (4) @(posedge clk_i);
      chk(32'({bus_if.irq_pin, bus_if.irq_pin_oe, bus_if.dma_request_pin, irq_act, dreq_act}),
          32'({~c[7:5], 2'h0}));
      for (int j = 0; j < 2; j++) begin
        d = 8'($urandom);
        push_seen <= 2'h0;
        wb(1'b1, 10'(ADDR_DMA_WR_LO + j), d);
        chk(32'({push_seen, push_byte}), 32'({lane(8'(ADDR_DMA_WR_LO + j), c), d}));
      end
    end
    $display("config and write port test done");
    set(ADDR_BUS_CFG, 8'h05);
    rdchk(10'(ADDR_BUS_CFG), c);
    dmode <= 1'b0;
    push_seen <= 2'h0;
    wb(1'b1, 10'(ADDR_DMA_WR_HI), 8'h5A);
    chk(32'(push_seen), 32'h0);
    wb(1'b1, HOST_STAT_IDX, 8'h01);
    wb(1'b1, HOST_CTRL_IDX, 8'h02);
    wb(1'b1, 10'(ADDR_DMA_WR_LO), 8'hA5);
    wb(1'b0, HOST_STAT_IDX, 8'h00);
    chk(32'(rq[0]), 32'h1);
    wb(1'b1, 10'(ADDR_LOCK), RELOCK_VALUE);
    cut <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(32'(xclk_en), 32'h0);
    {cut, srst} <= 2'h1;
    repeat (2) @(posedge clk_i);
    srst <= 1'b0;
    rdchk(10'(ADDR_LOCK), LOCK_RESET);
    rdchk(10'(ADDR_CLK_SEL), CLK_SEL_RESET);
    $display("refusal and soft reset test done");
    summarize();
  end
  initial begin
    #400000;
    failures++;
    summarize();
  end
endmodule : host_cpu_port_config_regs_test
